// ==== design/acr_conv.sv ====
`timescale 1ns/10ps
module acr_conv import acr_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic start,
	input wire logic [9:0] code_in,
	output logic track,
	output logic busy,
	output logic done,
	output logic [9:0] result
);
	typedef struct packed {
		acr_cv_t ph;
		logic [CNT_W-1:0] cnt;
		logic done;
		logic [9:0] res;
	} acr_conv_st_t;

	localparam acr_conv_st_t ACR_CONV_RST = '{ph: CV_IDLE, cnt: '0, done: 1'b0, res: RES_RST};

	acr_conv_st_t st_r;
	acr_conv_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		case (st_r.ph)
			CV_IDLE: begin
				// Starts while busy are dropped, not queued
				if (start) begin
					st_nxt.ph = CV_TRACK; // R1
					st_nxt.cnt = '0;
				end
			end
			CV_TRACK: begin
				if (st_r.cnt == CNT_W'(TRACK_CYC - 1)) begin
					st_nxt.ph = CV_HOLD; // R4
					st_nxt.cnt = '0;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			CV_HOLD: begin
				if (st_r.cnt == CNT_W'(CONVERT_CYC - 1)) begin
					st_nxt.res = code_in;
					st_nxt.done = 1'b1;
					st_nxt.ph = CV_IDLE;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			default: st_nxt.ph = CV_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ACR_CONV_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign track = (st_r.ph == CV_TRACK);
	assign busy = (st_r.ph != CV_IDLE);
	assign done = st_r.done;
	assign result = st_r.res;

	property p_start;
		@(posedge clk) disable iff (!rst_b) (ce && start && !busy) |=> track;
	endproperty
	a_start: assert property (p_start) else $error("conversion did not enter track"); // R1

	property p_track_len;
		@(posedge clk) disable iff (!rst_b)
			(ce && track && st_r.cnt == CNT_W'(TRACK_CYC - 1)) |=> (!track && busy);
	endproperty
	a_track_len: assert property (p_track_len) else $error("track phase length wrong"); // R4
endmodule // acr_conv

// ==== design/acr_pkg.sv ====
package acr_pkg;
	localparam int CLK_MHZ = 125;
	localparam int TRACK_NS = 400;
	// Least sampling time, rounded up to whole cycles
	localparam int TRACK_CYC = (TRACK_NS * CLK_MHZ + 999) / 1000;
	localparam int CONVERT_CYC = 64;
	localparam int CNT_W = 8;
	localparam int TMR_W = 24;
	localparam logic [2:0] PTR_RESULT = 3'h0;
	localparam logic [2:0] PTR_STATUS = 3'h1;
	localparam logic [2:0] PTR_CONFIG = 3'h2;
	localparam logic [2:0] PTR_LOW = 3'h3;
	localparam logic [2:0] PTR_HIGH = 3'h4;
	localparam logic [2:0] PTR_HYST = 3'h5;
	localparam logic [2:0] PTR_MIN = 3'h6;
	localparam logic [2:0] PTR_MAX = 3'h7;
	localparam logic [2:0] PTR_RST = 3'h0;
	localparam int RES_LSB = 2;
	localparam int RES_MSB = 11;
	localparam int ALERT_BIT = 15;
	localparam int CFG_CYC_MSB = 7;
	localparam int CFG_CYC_LSB = 5;
	localparam int CFG_HOLD_BIT = 4;
	localparam int CFG_FLAG_EN_BIT = 3;
	localparam int FLG_OVER = 1;
	localparam int FLG_UNDER = 0;
	localparam logic [3:0] AUTO_SHIFT_BASE = 4'h4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] CFG_WMASK = 8'hFD;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [1:0] FLG_RST = 2'h0;
	localparam logic [9:0] RES_RST = 10'h000;
	localparam logic [9:0] LOW_RST = 10'h000;
	localparam logic [9:0] HIGH_RST = 10'h3FF;
	localparam logic [9:0] HYST_RST = 10'h000;
	localparam logic [9:0] MIN_RST = 10'h3FF;
	localparam logic [9:0] MAX_RST = 10'h000;

	typedef enum logic [2:0] {BP_IDLE, BP_ADDR, BP_AACK, BP_WDATA, BP_WACK, BP_RDATA, BP_RACK} acr_bus_t;
	typedef enum logic [1:0] {CV_IDLE, CV_TRACK, CV_HOLD} acr_cv_t;

	function automatic logic [15:0] acr_word(input logic [9:0] v);
		logic [15:0] w;
		w = 16'h0000;
		w[RES_MSB:RES_LSB] = v;
		return w;
	endfunction

	function automatic logic [9:0] acr_field(input logic [15:0] w);
		return w[RES_MSB:RES_LSB];
	endfunction
endpackage

// ==== design/acr_regs.sv ====
`timescale 1ns/10ps
// Overview of operation
// R1 - Conversion cycle starts at acknowledge falling edge
// R2 - Result read or automatic mode starts conversion
// R3 - Automatic interval chosen by cycle-time field
// R4 - Input tracked fixed cycles, then converted
// R5 - Result sits in bits 11:2, straight binary
// R6 - Power-on reset loads every register default
// R7 - First write byte loads the register pointer
// R8 - Three pointer bits select eight registers
// R9 - Controller writes zero to upper pointer bits
// R10 - Pointer resets to result register
// R11 - Result register is read-only
// R12 - Bit 15 shows enabled alert summary
// R13 - Reserved bits read zero, written zero; config bits 2 and 0 keep the value written and read back as written
// R14 - Over-range flag sets above upper limit
// R15 - Over-range clears by write-one or hysteresis
// R16 - Under-range flag sets below lower limit
// R17 - Under-range clears by write-one or hysteresis
// R18 - Alert flags are active high
// R19 - Automatic mode tracks lowest and highest result
// R20 - Zero cycle-time field disables automatic mode
// R21 - Sticky bit stops flag self-clearing
// R22 - Configuration bit 3 enables summary bit
// R23 - Min/max update only in automatic mode
// R24 - Limits checked once per completed conversion
module acr_regs import acr_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary default
	parameter int AUTO_UNIT_CYC = 128
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic [9:0] ANALOG_CODE,
	output logic SDA_OUT,
	output logic SDA_OE_B,
	output logic TRACK,
	output logic BUSY
);
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f;
		logic sda_f;
		acr_bus_t ph;
		logic [3:0] bitc;
		logic [7:0] shf;
		logic rw;
		logic first;
		logic bsel;
		logic [7:0] hold;
		logic [15:0] rdw;
		logic oe_b;
		logic [2:0] ptr;
		logic [7:0] cfg;
		logic [9:0] lo;
		logic [9:0] hi;
		logic [9:0] hyst;
		logic [9:0] lowest_result_store;
		logic [9:0] highest_result_store;
		logic [9:0] res;
		logic [1:0] flg;
		logic [TMR_W-1:0] tmr;
		logic go;
	} acr_st_t;

	localparam acr_st_t ACR_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
		ph: BP_IDLE, bitc: 4'h0, shf: 8'h00, rw: 1'b0, first: 1'b0, bsel: 1'b0,
		hold: 8'h00, rdw: 16'h0000, oe_b: 1'b1, ptr: PTR_RST, cfg: CFG_RST, lo: LOW_RST,
		hi: HIGH_RST, hyst: HYST_RST, lowest_result_store: MIN_RST,
		highest_result_store: MAX_RST, res: RES_RST,
		flg: FLG_RST, tmr: '0, go: 1'b0};

	function automatic logic acr_narrow(input logic [2:0] p);
		return (p == PTR_STATUS) || (p == PTR_CONFIG);
	endfunction

	function automatic logic [TMR_W-1:0] acr_interval(input logic [2:0] code);
		return TMR_W'(AUTO_UNIT_CYC) << (4'(code) + AUTO_SHIFT_BASE);
	endfunction

	acr_st_t st_r;
	acr_st_t st_nxt;
	logic scl_n;
	logic sda_n;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic auto_on;
	logic [15:0] rd_word;
	logic wr_en;
	logic [2:0] wr_ptr;
	logic [15:0] wr_word;
	logic ptr_load;
	logic do_load;
	logic ld_s;
	logic [15:0] ld_w;
	logic [7:0] ld_b;
	logic [1:0] w1c;
	logic [1:0] flg_set;
	logic [1:0] flg_clr;
	logic cv_done;
	logic cv_busy;
	logic [9:0] cv_res;

	acr_conv u_conv (
		.clk(CLK),
		.rst_b(RST_B),
		.ce(CE),
		.start(st_r.go),
		.code_in(ANALOG_CODE),
		.track(TRACK),
		.busy(cv_busy),
		.done(cv_done),
		.result(cv_res)
	);

	// Pin filter: a level counts once the last two stages agree
	assign scl_n = (st_r.scl_s[1] == st_r.scl_s[2]) ? st_r.scl_s[2] : st_r.scl_f;
	assign sda_n = (st_r.sda_s[1] == st_r.sda_s[2]) ? st_r.sda_s[2] : st_r.sda_f;
	assign scl_rise = scl_n && !st_r.scl_f;
	assign scl_fall = !scl_n && st_r.scl_f;
	assign bus_start = st_r.scl_f && scl_n && st_r.sda_f && !sda_n;
	assign bus_stop = st_r.scl_f && scl_n && !st_r.sda_f && sda_n;
	assign auto_on = (st_r.cfg[CFG_CYC_MSB:CFG_CYC_LSB] != 3'h0); // R20

	always_comb begin
		rd_word = 16'h0000;
		case (st_r.ptr) // R8
			PTR_RESULT: begin
				rd_word = acr_word(st_r.res); // R5 R13
				rd_word[ALERT_BIT] = st_r.cfg[CFG_FLAG_EN_BIT] && (st_r.flg != 2'h0); // R12 R22
			end
			PTR_STATUS: rd_word = 16'(st_r.flg); // R13 R18
			PTR_CONFIG: rd_word = 16'(st_r.cfg);
			PTR_LOW: rd_word = acr_word(st_r.lo);
			PTR_HIGH: rd_word = acr_word(st_r.hi);
			PTR_HYST: rd_word = acr_word(st_r.hyst);
			PTR_MIN: rd_word = acr_word(st_r.lowest_result_store);
			PTR_MAX: rd_word = acr_word(st_r.highest_result_store);
			default: rd_word = 16'h0000;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.go = 1'b0;
		st_nxt.scl_s = {st_r.scl_s[1:0], SCL_IN};
		st_nxt.sda_s = {st_r.sda_s[1:0], SDA_IN};
		st_nxt.scl_f = scl_n;
		st_nxt.sda_f = sda_n;
		wr_en = 1'b0;
		wr_ptr = st_r.ptr;
		wr_word = 16'h0000;
		ptr_load = 1'b0;
		do_load = 1'b0;
		ld_s = 1'b0;
		ld_w = st_r.rdw;
		ld_b = 8'h00;
		w1c = 2'h0;
		flg_set = 2'h0;
		flg_clr = 2'h0;
		if (bus_start) begin
			st_nxt.ph = BP_ADDR;
			st_nxt.bitc = 4'h0;
			st_nxt.oe_b = 1'b1;
		end else if (bus_stop) begin
			st_nxt.ph = BP_IDLE;
			st_nxt.oe_b = 1'b1;
		end else if (scl_rise) begin
			case (st_r.ph)
				BP_ADDR, BP_WDATA: begin
					st_nxt.shf = {st_r.shf[6:0], sda_n};
					st_nxt.bitc = st_r.bitc + 1'b1;
				end
				BP_RACK: begin
					// Controller NACK ends the read
					if (sda_n) begin
						st_nxt.ph = BP_IDLE;
					end
				end
				default: st_nxt.ph = st_r.ph;
			endcase
		end else if (scl_fall) begin
			case (st_r.ph)
				BP_ADDR: begin
					if (st_r.bitc == BITS_PER_BYTE && st_r.shf[7:1] == DEV_ADDR) begin
						st_nxt.oe_b = 1'b0;
						st_nxt.ph = BP_AACK;
						st_nxt.rw = st_r.shf[0];
						st_nxt.bsel = 1'b0;
						// Snapshot before the new conversion overwrites it
						st_nxt.rdw = rd_word;
						if (st_r.shf[0] && st_r.ptr == PTR_RESULT && !auto_on) begin
							st_nxt.go = 1'b1; // R1 R2
						end
					end else if (st_r.bitc == BITS_PER_BYTE) begin
						st_nxt.ph = BP_IDLE;
					end
				end
				BP_AACK: begin
					if (st_r.rw) begin
						do_load = 1'b1;
					end else begin
						st_nxt.oe_b = 1'b1;
						st_nxt.ph = BP_WDATA;
						st_nxt.first = 1'b1;
						st_nxt.bitc = 4'h0;
					end
				end
				BP_WDATA: begin
					if (st_r.bitc == BITS_PER_BYTE) begin
						st_nxt.oe_b = 1'b0;
						st_nxt.ph = BP_WACK;
						st_nxt.bitc = 4'h0;
						if (st_r.first) begin
							ptr_load = 1'b1;
							st_nxt.ptr = st_r.shf[2:0]; // R7 R9
							st_nxt.first = 1'b0;
							st_nxt.bsel = 1'b0;
						end else if (acr_narrow(st_r.ptr)) begin
							wr_en = 1'b1;
							wr_word = 16'(st_r.shf);
						end else if (!st_r.bsel) begin
							st_nxt.hold = st_r.shf;
							st_nxt.bsel = 1'b1;
						end else begin
							wr_en = 1'b1;
							wr_word = {st_r.hold, st_r.shf};
							st_nxt.bsel = 1'b0;
						end
					end
				end
				BP_WACK: begin
					st_nxt.oe_b = 1'b1;
					st_nxt.ph = BP_WDATA;
				end
				BP_RDATA: begin
					if (st_r.bitc == BITS_PER_BYTE) begin
						st_nxt.oe_b = 1'b1;
						st_nxt.ph = BP_RACK;
					end else begin
						st_nxt.oe_b = st_r.shf[7];
						st_nxt.shf = {st_r.shf[6:0], 1'b0};
						st_nxt.bitc = st_r.bitc + 1'b1;
					end
				end
				BP_RACK: begin
					do_load = 1'b1;
					ld_s = !acr_narrow(st_r.ptr) && !st_r.bsel;
					ld_w = ld_s ? st_r.rdw : rd_word;
				end
				default: st_nxt.ph = BP_IDLE;
			endcase
		end
		// Byte out: wide registers send high byte then low byte
		if (do_load) begin
			ld_b = (!acr_narrow(st_r.ptr) && !ld_s) ? ld_w[15:8] : ld_w[7:0];
			st_nxt.rdw = ld_w;
			st_nxt.bsel = ld_s;
			st_nxt.oe_b = ld_b[7];
			st_nxt.shf = {ld_b[6:0], 1'b0};
			st_nxt.bitc = 4'h1;
			st_nxt.ph = BP_RDATA;
		end
		if (wr_en) begin
			case (wr_ptr)
				PTR_STATUS: w1c = wr_word[1:0]; // R15 R17
				PTR_CONFIG: st_nxt.cfg = wr_word[7:0] & CFG_WMASK; // R13
				PTR_LOW: st_nxt.lo = acr_field(wr_word);
				PTR_HIGH: st_nxt.hi = acr_field(wr_word);
				PTR_HYST: st_nxt.hyst = acr_field(wr_word);
				PTR_MIN: st_nxt.lowest_result_store = acr_field(wr_word);
				PTR_MAX: st_nxt.highest_result_store = acr_field(wr_word);
				default: st_nxt.res = st_r.res; // R11
			endcase
		end
		// Automatic interval timer; restarts whenever the mode is off
		if (!auto_on) begin
			st_nxt.tmr = '0; // R20
		end else if (st_r.tmr >= acr_interval(st_r.cfg[CFG_CYC_MSB:CFG_CYC_LSB]) - 1'b1) begin
			st_nxt.tmr = '0;
			st_nxt.go = 1'b1; // R2 R3
		end else begin
			st_nxt.tmr = st_r.tmr + 1'b1;
		end
		if (cv_done) begin
			st_nxt.res = cv_res; // R24
			flg_set[FLG_OVER] = cv_res > st_r.hi; // R14
			flg_set[FLG_UNDER] = cv_res < st_r.lo; // R16
			if (!st_r.cfg[CFG_HOLD_BIT]) begin
				flg_clr[FLG_OVER] = ({1'b0, cv_res} + {1'b0, st_r.hyst}) < {1'b0, st_r.hi}; // R15 R21
				flg_clr[FLG_UNDER] = {1'b0, cv_res} > ({1'b0, st_r.lo} + {1'b0, st_r.hyst}); // R17 R21
			end
			if (auto_on) begin
				if (cv_res < st_nxt.lowest_result_store) begin
					st_nxt.lowest_result_store = cv_res; // R19 R23
				end
				if (cv_res > st_nxt.highest_result_store) begin
					st_nxt.highest_result_store = cv_res; // R19 R23
				end
			end
		end
		// An alert arriving with a clear keeps the flag set
		st_nxt.flg = (st_r.flg & ~w1c & ~flg_clr) | flg_set; // R18
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r <= ACR_RST; // R6 R10
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_B = st_r.oe_b;
	assign BUSY = cv_busy;

	property p_over_set;
		@(posedge CLK) disable iff (!RST_B) (CE && cv_done && cv_res > st_r.hi) |=> st_r.flg[FLG_OVER];
	endproperty
	a_over_set: assert property (p_over_set) else $error("over-range flag not set"); // R14

	property p_under_set;
		@(posedge CLK) disable iff (!RST_B) (CE && cv_done && cv_res < st_r.lo) |=> st_r.flg[FLG_UNDER];
	endproperty
	a_under_set: assert property (p_under_set) else $error("under-range flag not set"); // R16

	property p_hold_sticky;
		@(posedge CLK) disable iff (!RST_B)
			(CE && st_r.cfg[CFG_HOLD_BIT] && st_r.flg[FLG_OVER] && !(wr_en && wr_ptr == PTR_STATUS))
			|=> st_r.flg[FLG_OVER];
	endproperty
	a_hold_sticky: assert property (p_hold_sticky) else $error("sticky flag cleared itself"); // R21

	property p_ro_result;
		@(posedge CLK) disable iff (!RST_B) (CE && wr_en && wr_ptr == PTR_RESULT && !cv_done) |=> $stable(st_r.res);
	endproperty
	a_ro_result: assert property (p_ro_result) else $error("result register was written"); // R11

	property p_minmax_normal;
		@(posedge CLK) disable iff (!RST_B) (CE && !auto_on && !wr_en)
			|=> ($stable(st_r.lowest_result_store) && $stable(st_r.highest_result_store));
	endproperty
	a_minmax_normal: assert property (p_minmax_normal) else $error("min/max moved in normal mode"); // R23

	property p_ptr_load;
		@(posedge CLK) disable iff (!RST_B) (CE && ptr_load) |=> (st_r.ptr == $past(st_r.shf[2:0]));
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded from first byte"); // R7

	property p_read_conv;
		@(posedge CLK) disable iff (!RST_B) (CE && st_r.go && !cv_busy) |=> TRACK [*8];
	endproperty
	a_read_conv: assert property (p_read_conv) else $error("conversion did not track"); // R4

	property p_result_field;
		@(posedge CLK) disable iff (!RST_B)
			(CE && cv_done && st_r.ptr == PTR_RESULT) |=> (rd_word[RES_MSB:RES_LSB] == $past(cv_res));
	endproperty
	a_result_field: assert property (p_result_field) else $error("result not in bits 11:2"); // R5
endmodule // acr_regs

// ==== tb/acr_bus_ctrl_model.sv ====
`timescale 1ns/10ps
module acr_bus_ctrl_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv,
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data moves only mid-low so it never looks like a start or stop
	task automatic bit_w(input logic b);
		sda_drv <= b;
		tick(4);
		scl <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	// Sampled on the falling clock edge, clear of the design's updates
	task automatic bit_r(output logic b);
		sda_drv <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		@(negedge clk);
		b = sda;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic start();
		sda_drv <= 1'b0;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(8);
		sda_drv <= 1'b1;
		tick(16);
	endtask
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_w(d[i]);
		end
		bit_r(b);
		ack = ~b;
	endtask
	task automatic byte_r(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_r(d[i]);
		end
		rd_byte <= d;
		rd_valid <= 1'b1;
		tick(1);
		rd_valid <= 1'b0;
		bit_w(last);
	endtask
endmodule // acr_bus_ctrl_model

// ==== tb/adc_conversion_alert_regs_bench.sv ====
`timescale 1ns/10ps
module adc_conversion_alert_regs_bench import acr_pkg::*; ;
	localparam logic [6:0] ADDR = 7'h2A; // Arbitrary bus address
	localparam int UNIT = 4; // Short unit keeps automatic runs brief
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [9:0] code = 10'h000;
	logic [9:0] c0;
	logic scl, sda_drv, rd_valid, sda_out, sda_oe_b, track, busy;
	logic [7:0] rd_byte;
	wire sda = sda_drv & (sda_oe_b | sda_out);
	logic [7:0] expq[$];
	int failures = 0;
	int checked = 0;
	int seed = 57772;
	int trk = 0;
	int gap = 0;

	acr_regs #(.DEV_ADDR(ADDR), .AUTO_UNIT_CYC(UNIT)) uut (.CLK(clk), .RST_B(rst_b), .CE(ce),
		.SCL_IN(scl), .SDA_IN(sda), .ANALOG_CODE(code), .SDA_OUT(sda_out),
		.SDA_OE_B(sda_oe_b), .TRACK(track), .BUSY(busy));
	acr_bus_ctrl_model m (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv),
		.rd_valid(rd_valid), .rd_byte(rd_byte));

	initial begin
		forever #4 clk = ~clk;
	end

	function automatic logic [15:0] w16(input logic [9:0] v);
		return {4'h0, v, 2'b00};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("counts: %0d checked, %0d failures", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] p, input int n, input logic [15:0] d);
		logic a;
		m.start();
		m.byte_w({ADDR, 1'b0}, a);
		check(16'(a), 16'h0001);
		m.byte_w({5'h00, p}, a);
		if (n == 2) m.byte_w(d[15:8], a);
		if (n > 0) m.byte_w(d[7:0], a);
		m.stop();
	endtask
	// Notes expected bytes, the monitor compares them
	task automatic rd(input int n, input logic [15:0] e);
		logic a;
		logic [7:0] b;
		if (n == 2) expq.push_back(e[15:8]);
		expq.push_back(e[7:0]);
		m.start();
		m.byte_w({ADDR, 1'b1}, a);
		if (n == 2) m.byte_r(1'b0, b);
		m.byte_r(1'b1, b);
		m.stop();
	endtask
	task automatic settle();
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
		if (busy !== 1'b0) begin
			failures++;
			$display("mismatch at %0t: conversion never finished", $time);
			tally_and_finish();
		end
	endtask
	task automatic wait_trk(input logic lvl);
		for (int i = 0; i < 400 && track !== lvl; i++) @(posedge clk);
		if (track !== lvl) begin
			failures++;
			$display("mismatch at %0t: track level never came", $time);
			tally_and_finish();
		end
	endtask

	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			if (expq.size() == 0) begin
				failures++;
				$display("mismatch at %0t: unexpected byte", $time);
			end else begin
				check(16'(rd_byte), 16'(expq.pop_front()));
			end
		end
		if (track === 1'b1) begin
			// Frozen cycles do not advance the phase
			if (ce) trk = trk + 1;
		end else begin
			if (trk != 0) check(16'(trk), 16'(TRACK_CYC));
			trk = 0;
		end
	end

	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		$display("mismatch at %0t: run timed out", $time);
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		code <= 10'($random(seed));
		repeat (4) @(posedge clk);
		rd(2, 16'h0000);
		settle();
		c0 = code;
		wr(3'h0, 2, 16'hFFFF);
		rd(2, w16(c0));
		settle();
		wr(3'h4, 0, 16'h0000);
		rd(2, 16'h0FFC);
		wr(3'h6, 0, 16'h0000);
		rd(2, 16'h0FFC);
		$display("test reset_and_pointer done");
		wr(3'h3, 2, 16'h0400);
		rd(2, 16'h0400);
		wr(3'h4, 2, 16'h0800);
		wr(3'h5, 2, 16'h0040);
		wr(3'h2, 1, 16'h0008);
		code <= 10'h250;
		wr(3'h0, 0, 16'h0000);
		rd(2, w16(c0));
		settle();
		wr(3'h1, 0, 16'h0000);
		rd(1, 16'h0002);
		code <= 10'h1F8;
		wr(3'h0, 0, 16'h0000);
		rd(2, 16'h8000 | w16(10'h250));
		settle();
		code <= 10'h0F0;
		rd(2, 16'h8000 | w16(10'h1F8));
		settle();
		wr(3'h1, 0, 16'h0000);
		rd(1, 16'h0001);
		wr(3'h1, 1, 16'h0001);
		rd(1, 16'h0000);
		wr(3'h2, 1, 16'h0018);
		code <= 10'h250;
		wr(3'h0, 0, 16'h0000);
		rd(2, w16(10'h0F0));
		settle();
		code <= 10'h180;
		rd(2, 16'h8000 | w16(10'h250));
		settle();
		wr(3'h1, 0, 16'h0000);
		rd(1, 16'h0002);
		wr(3'h1, 1, 16'h0002);
		rd(1, 16'h0000);
		$display("test alerts done");
		code <= 10'h100;
		wr(3'h2, 1, 16'h0020);
		wait_trk(1'b1);
		wait_trk(1'b0);
		for (gap = 0; gap < 400 && track !== 1'b1; gap++) @(posedge clk);
		check(16'(gap), 16'(32 * UNIT - TRACK_CYC));
		repeat (600) @(posedge clk);
		code <= 10'h300;
		repeat (600) @(posedge clk);
		wait_trk(1'b1);
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		check(16'(track), 16'h0001);
		ce <= 1'b1;
		code <= 10'h200;
		repeat (600) @(posedge clk);
		wr(3'h2, 1, 16'h0000);
		settle();
		repeat (200) @(posedge clk);
		check(16'(busy), 16'h0000);
		wr(3'h6, 0, 16'h0000);
		rd(2, w16(10'h100));
		wr(3'h7, 0, 16'h0000);
		rd(2, w16(10'h300));
		$display("test automatic done");
		check(16'(expq.size()), 16'h0000);
		tally_and_finish();
	end
endmodule // adc_conversion_alert_regs_bench
